// ---- rtl/cpsys_pkg.sv ----
package cpsys_pkg;

    // Clock and timing
    localparam int unsigned MCLK_DIV = 2;
    localparam int unsigned XTAL_REF_HZ = 4_000_000;
    localparam int unsigned TICK_REF_HZ = 31_250;
    localparam int unsigned TICK_DIV_DEF = XTAL_REF_HZ / TICK_REF_HZ;

    // APB register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMER = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_VEC = 8'h0C;
    localparam logic [7:0] OFS_BCMD = 8'h10;
    localparam logic [7:0] OFS_BDATA = 8'h14;
    localparam logic [7:0] OFS_INP = 8'h18;

    // Control register fields
    localparam int CTRL_FLAG_A = 0;
    localparam int CTRL_FLAG_B = 1;
    localparam int CTRL_LCD_ON = 2;
    localparam int CTRL_IRQ_ALLOW = 3;
    localparam int CTRL_POWER_OFF = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Status register fields
    localparam int ST_NMI_PEND = 0;
    localparam int ST_TMR_PEND = 1;
    localparam int ST_MI_PEND = 2;
    localparam int ST_BACKUP = 3;
    localparam int ST_STALL = 4;
    localparam int ST_GRANT = 5;
    localparam int ST_RESET_IN = 6;
    localparam int ST_IRQ_REQ = 7;
    localparam int BDATA_BUSY = 31;

    // Vector addresses (high byte location, low byte location)
    localparam logic [15:0] VEC_RESET_HI = 16'hFFFE;
    localparam logic [15:0] VEC_RESET_LO = 16'hFFFF;
    localparam logic [15:0] VEC_NMI_HI = 16'hFFFC;
    localparam logic [15:0] VEC_NMI_LO = 16'hFFFD;
    localparam logic [15:0] VEC_TMR_HI = 16'hFFFA;
    localparam logic [15:0] VEC_TMR_LO = 16'hFFFB;
    localparam logic [15:0] VEC_MI_HI = 16'hFFF8;
    localparam logic [15:0] VEC_MI_LO = 16'hFFF9;

    // Timer
    localparam int TMR_W = 9;
    localparam logic [8:0] TMR_FULL = 9'h1FF;
    localparam logic [8:0] TMR_STOP = 9'h000;
    localparam int TMR_TAP_A = 0;
    localparam int TMR_TAP_B = 4;

    // Backplate
    localparam int BP_W = 8;
    localparam logic [7:0] BP_RING_INIT = 8'h01;

    // Bus command word written to OFS_BCMD
    typedef struct packed {
        logic port;
        logic code;
        logic opcode;
        logic space_b;
        logic write;
        logic [7:0] data;
        logic [15:0] addr;
    } cpsys_cmd_t;
    localparam int CMD_W = 29;

    // External bus pin values
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] data;
        logic sel_a;
        logic sel_b;
        logic rw_n;
        logic drive_inhibit;
    } cpsys_bus_t;

    typedef enum logic [2:0] {
        BS_IDLE = 3'b001,
        BS_MEM = 3'b010,
        BS_PORT = 3'b100
    } cpsys_bst_t;

endpackage : cpsys_pkg

// ---- rtl/cpsys_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Machine clock is the input clock divided by two.
// - Address outputs float while an external bus hold is granted.
// - Two space selects each reach a separate 64K space, 128K total.
// - Fetch and stack accesses always use space A; data picks either.
// - Clock output pin runs in phase with the machine clock.
// - Write cycles drive read/write low with write data on the bus.
// - Drive inhibit stays high during write cycles.
// - While reset input is high, vector points at FFFE/FFFF.
// - Non-maskable event always served, vector FFFC/FFFD.
// - Maskable input served only when allowed, vector FFF8/FFF9.
// - Bus request raises grant; grant floats address, data and strobes.
// - Opcode strobe only on opcode fetches, never on operand bytes.
// - Eight parallel input lines are readable as one byte.
// - Port latch clock high presents the accumulator byte on the bus.
// - Two user flags change only by explicit set or clear.
// - Wait sampled at clock-out falling edge; latch high stops the clock.
// - Backplate lines come from a counter on the backplate clock input.
// - LCD on control changes only by explicit command.
// - Backup latch set by input rise, cleared by power-off; pin inverted.
// - Timer is a 9-bit polynomial counter loaded by software.
// - Timer reaching 1FF raises request; allowed vector FFFA/FFFB.
// - Timer steps once per slow tick while its count is nonzero.
// - Timer follows the 511-state sequence; 1FE then 1FF then 0FF.
// - Timer holds while zero, counts for any other value.
// - Interrupt rises set pending flags, cleared during processing.
module cpsys_top #(
    parameter int unsigned TICK_DIV = cpsys_pkg::TICK_DIV_DEF
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External bus
    output cpsys_pkg::cpsys_bus_t bus_pins,
    output logic addr_oe_n,
    output logic ctl_oe_n,
    output logic data_oe_n,
    input wire logic [7:0] data_in,
    output logic opcode_fetch_strobe,
    output logic port_latch_clk,
    output logic clock_out_pin,
    input wire logic wait_in,
    // Bus hold
    input wire logic bus_hold_request,
    output logic bus_hold_grant,
    // Reset and interrupt pins
    input wire logic cpu_reset_in,
    input wire logic nonmask_irq_in,
    input wire logic maskable_irq_in,
    // Misc pins
    input wire logic [7:0] parallel_input_lines,
    output logic user_flag_a,
    output logic user_flag_b,
    output logic lcd_on_ctl,
    output logic lcd_divider_tap,
    input wire logic backplate_counter_clk,
    output logic [7:0] backplate_lines,
    input wire logic backup_set_in,
    output logic backup_state_n
);
    import cpsys_pkg::*;

    generate
        if (TICK_DIV < 2 || TICK_DIV > 65536) begin : g_bad_div
            $error("TICK_DIV out of range");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic phase_ff, stall_latch_ff;
    logic [3:0] ctrl_ff;
    logic [8:0] timer_count_ff;
    logic [15:0] tick_cnt_ff;
    logic nonmask_pending_ff, tmr_pend_ff, mi_pend_ff;
    logic nmi_prev_ff, mi_prev_ff, bk_prev_ff, bp_prev_ff;
    logic [7:0] bp_ring_ff;
    logic cmd_valid_ff;
    cpsys_cmd_t cmd_ff;
    cpsys_bst_t bst_ff;
    logic [7:0] rdata_ff;
    logic [31:0] nxt_prdata;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    wire setup_w = psel && !penable;
    wire acc_w = psel && penable && pready;
    wire wr_w = acc_w && pwrite;
    wire sel_ctrl = paddr == OFS_CTRL;
    wire sel_timer = paddr == OFS_TIMER;
    wire sel_stat = paddr == OFS_STAT;
    wire sel_vec = paddr == OFS_VEC;
    wire sel_bcmd = paddr == OFS_BCMD;
    wire sel_bdata = paddr == OFS_BDATA;
    wire sel_inp = paddr == OFS_INP;
    wire mapped_w = sel_ctrl | sel_timer | sel_stat | sel_vec | sel_bcmd | sel_bdata | sel_inp;
    wire busy_w = cmd_valid_ff || (bst_ff != BS_IDLE);
    wire nxt_err = !mapped_w || (pwrite && sel_bcmd && busy_w)
                   || (pwrite && (sel_vec || sel_bdata || sel_inp));
    wire ctrl_wr = wr_w && sel_ctrl;
    wire timer_wr = wr_w && sel_timer;
    wire stat_wr = wr_w && sel_stat;
    wire bcmd_wr = wr_w && sel_bcmd && !pslverr; // Refusal decided at setup

    ////////////////////////////////////////////////////////////////////////////
    // Machine clock, wait latch, slow tick

    wire mtick = !phase_ff && !stall_latch_ff;
    wire tick_w = tick_cnt_ff == 16'h0000;
    wire [15:0] tick_top = 16'(TICK_DIV - 1);
    wire irq_allow = ctrl_ff[CTRL_IRQ_ALLOW];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            phase_ff <= 1'b0;
            stall_latch_ff <= 1'b0;
            tick_cnt_ff <= 16'h0000;
            lcd_divider_tap <= 1'b0;
        end else begin
            if (!stall_latch_ff)
                phase_ff <= !phase_ff;
            if (phase_ff || stall_latch_ff)
                stall_latch_ff <= wait_in;
            tick_cnt_ff <= tick_w ? tick_top : tick_cnt_ff - 16'h0001;
            if (tick_w)
                lcd_divider_tap <= !lcd_divider_tap;
        end
    end

    assign clock_out_pin = phase_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Control, timer and pending flags

    wire [8:0] tmr_step = {timer_count_ff[TMR_TAP_A] ^ timer_count_ff[TMR_TAP_B],
                           timer_count_ff[8:1]};
    wire tmr_run = tick_w && (timer_count_ff != TMR_STOP);
    wire tmr_hit = tmr_run && (tmr_step == TMR_FULL);
    wire nmi_rise = mtick && nonmask_irq_in && !nmi_prev_ff;
    wire mi_rise = mtick && maskable_irq_in && !mi_prev_ff;
    wire bk_rise = backup_set_in && !bk_prev_ff;
    wire power_off = ctrl_wr && pwdata[CTRL_POWER_OFF];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_ff <= CTRL_RESET;
            timer_count_ff <= TMR_STOP;
            nonmask_pending_ff <= 1'b0;
            tmr_pend_ff <= 1'b0;
            mi_pend_ff <= 1'b0;
            nmi_prev_ff <= 1'b0;
            mi_prev_ff <= 1'b0;
            bk_prev_ff <= 1'b0;
            backup_state_n <= 1'b1;
        end else begin
            if (ctrl_wr)
                ctrl_ff <= pwdata[3:0];
            if (timer_wr)
                timer_count_ff <= pwdata[8:0];
            else if (tmr_run)
                timer_count_ff <= tmr_step;
            if (mtick) begin
                nmi_prev_ff <= nonmask_irq_in;
                mi_prev_ff <= maskable_irq_in;
            end
            // Set wins over a same-cycle clear
            nonmask_pending_ff <= nmi_rise
                || (nonmask_pending_ff && !(stat_wr && pwdata[ST_NMI_PEND]));
            mi_pend_ff <= mi_rise
                || (mi_pend_ff && !(stat_wr && pwdata[ST_MI_PEND]));
            tmr_pend_ff <= tmr_hit
                || (tmr_pend_ff && !(stat_wr && pwdata[ST_TMR_PEND]));
            bk_prev_ff <= backup_set_in;
            if (bk_rise)
                backup_state_n <= 1'b0;
            else if (power_off)
                backup_state_n <= 1'b1;
        end
    end

    assign user_flag_a = ctrl_ff[CTRL_FLAG_A];
    assign user_flag_b = ctrl_ff[CTRL_FLAG_B];
    assign lcd_on_ctl = ctrl_ff[CTRL_LCD_ON];

    // Vector selection by priority
    wire tmr_serve = tmr_pend_ff && irq_allow;
    wire mi_serve = mi_pend_ff && irq_allow;
    wire irq_req = nonmask_pending_ff || tmr_serve || mi_serve;
    wire [31:0] vec_w = cpu_reset_in ? {VEC_RESET_LO, VEC_RESET_HI}
                      : nonmask_pending_ff ? {VEC_NMI_LO, VEC_NMI_HI}
                      : tmr_serve ? {VEC_TMR_LO, VEC_TMR_HI}
                      : mi_serve ? {VEC_MI_LO, VEC_MI_HI}
                      : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // LCD backplate counter

    wire bp_rise = backplate_counter_clk && !bp_prev_ff;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bp_prev_ff <= 1'b0;
            bp_ring_ff <= BP_RING_INIT;
            backplate_lines <= 8'h00;
        end else begin
            bp_prev_ff <= backplate_counter_clk;
            if (bp_rise)
                bp_ring_ff <= {bp_ring_ff[6:0], bp_ring_ff[7]};
            backplate_lines <= lcd_on_ctl ? bp_ring_ff : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External bus sequencer

    wire launch = (bst_ff == BS_IDLE) && cmd_valid_ff && mtick && !bus_hold_grant
                  && !bus_hold_request;
    wire finish = (bst_ff != BS_IDLE) && mtick;
    wire nxt_grant = bus_hold_request && (bst_ff == BS_IDLE) && !launch;
    wire use_b = !cmd_ff.code && cmd_ff.space_b;
    wire cmd_wr_cycle = cmd_ff.write && !cmd_ff.port;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bst_ff <= BS_IDLE;
            cmd_valid_ff <= 1'b0;
            cmd_ff <= '0;
            rdata_ff <= 8'h00;
            bus_hold_grant <= 1'b0;
            addr_oe_n <= 1'b1;
            ctl_oe_n <= 1'b1;
            data_oe_n <= 1'b1;
            opcode_fetch_strobe <= 1'b0;
            port_latch_clk <= 1'b0;
            bus_pins.addr <= 16'h0000;
            bus_pins.data <= 8'h00;
            bus_pins.sel_a <= 1'b0;
            bus_pins.sel_b <= 1'b0;
            bus_pins.rw_n <= 1'b1;
            bus_pins.drive_inhibit <= 1'b0;
        end else begin
            bus_hold_grant <= nxt_grant;
            addr_oe_n <= nxt_grant;
            ctl_oe_n <= nxt_grant;
            if (bcmd_wr) begin
                cmd_ff <= cpsys_cmd_t'(pwdata[CMD_W-1:0]);
                cmd_valid_ff <= 1'b1;
            end else if (launch) begin
                cmd_valid_ff <= 1'b0;
            end
            if (nxt_grant)
                data_oe_n <= 1'b1;
            if (launch) begin
                bus_pins.addr <= cmd_ff.addr;
                bus_pins.data <= cmd_ff.data;
                data_oe_n <= !(cmd_wr_cycle || cmd_ff.port);
                if (cmd_ff.port) begin
                    bst_ff <= BS_PORT;
                    port_latch_clk <= 1'b1;
                end else begin
                    bst_ff <= BS_MEM;
                    bus_pins.sel_a <= !use_b;
                    bus_pins.sel_b <= use_b;
                    bus_pins.rw_n <= !cmd_wr_cycle;
                    bus_pins.drive_inhibit <= cmd_wr_cycle;
                    opcode_fetch_strobe <= cmd_ff.opcode && cmd_ff.code && !cmd_ff.write;
                end
            end else if (finish) begin
                if (bst_ff == BS_MEM && !cmd_ff.write)
                    rdata_ff <= data_in;
                bst_ff <= BS_IDLE;
                data_oe_n <= 1'b1;
                port_latch_clk <= 1'b0;
                opcode_fetch_strobe <= 1'b0;
                bus_pins.sel_a <= 1'b0;
                bus_pins.sel_b <= 1'b0;
                bus_pins.rw_n <= 1'b1;
                bus_pins.drive_inhibit <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB read and answer

    wire [7:0] stat_w = {irq_req, cpu_reset_in, bus_hold_grant, stall_latch_ff,
                         !backup_state_n, mi_pend_ff, tmr_pend_ff, nonmask_pending_ff};

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (sel_ctrl)
            nxt_prdata[3:0] = ctrl_ff;
        if (sel_timer)
            nxt_prdata[8:0] = timer_count_ff;
        if (sel_stat)
            nxt_prdata[7:0] = stat_w;
        if (sel_vec)
            nxt_prdata = vec_w;
        if (sel_bdata)
            nxt_prdata = {busy_w, 23'h00_0000, rdata_ff};
        if (sel_inp)
            nxt_prdata[7:0] = parallel_input_lines;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_w;
            if (setup_w) begin
                prdata <= pwrite ? 32'h0000_0000 : nxt_prdata;
                pslverr <= nxt_err;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_phase_toggle:
    assert property (@(posedge clock) disable iff (!rst_n)
        !stall_latch_ff |=> clock_out_pin != $past(clock_out_pin))
        else $error("machine clock did not toggle");

    a_stall_freeze:
    assert property (@(posedge clock) disable iff (!rst_n)
        stall_latch_ff |=> clock_out_pin == $past(clock_out_pin))
        else $error("clock ran while stalled");

    a_grant_float:
    assert property (@(posedge clock) disable iff (!rst_n)
        bus_hold_grant |-> addr_oe_n && ctl_oe_n && data_oe_n)
        else $error("bus driven during grant");

    a_grant_answer:
    assert property (@(posedge clock) disable iff (!rst_n)
        bus_hold_request && bst_ff == BS_IDLE && !launch |=> bus_hold_grant ##0 addr_oe_n)
        else $error("grant not raised");

    a_fetch_space:
    assert property (@(posedge clock) disable iff (!rst_n)
        opcode_fetch_strobe |-> bus_pins.sel_a && !bus_pins.sel_b && bus_pins.rw_n)
        else $error("fetch not in space A");

    a_write_strobes:
    assert property (@(posedge clock) disable iff (!rst_n)
        !bus_pins.rw_n |-> !data_oe_n && bus_pins.drive_inhibit && bus_pins.data == cmd_ff.data)
        else $error("write cycle strobes wrong");

    a_timer_step:
    assert property (@(posedge clock) disable iff (!rst_n)
        tick_w && timer_count_ff != TMR_STOP && !timer_wr
        |=> timer_count_ff == {$past(timer_count_ff[0] ^ timer_count_ff[4]),
                               $past(timer_count_ff[8:1])})
        else $error("timer step wrong");

    a_timer_hold:
    assert property (@(posedge clock) disable iff (!rst_n)
        timer_count_ff == TMR_STOP && !timer_wr |=> timer_count_ff == TMR_STOP)
        else $error("stopped timer moved");

    a_timer_irq:
    assert property (@(posedge clock) disable iff (!rst_n)
        $changed(timer_count_ff) && timer_count_ff == TMR_FULL && !$past(timer_wr)
        |-> tmr_pend_ff)
        else $error("timer request missing");

    a_backup_set:
    assert property (@(posedge clock) disable iff (!rst_n)
        bk_rise |=> !backup_state_n ##1 (!backup_state_n || $past(power_off)))
        else $error("backup latch not set");

    a_nmi_pending:
    assert property (@(posedge clock) disable iff (!rst_n)
        nmi_rise |=> nonmask_pending_ff ##0 vec_w[15:0] == (cpu_reset_in ? VEC_RESET_HI : VEC_NMI_HI))
        else $error("nmi not pending");

    a_port_data:
    assert property (@(posedge clock) disable iff (!rst_n)
        port_latch_clk |-> !data_oe_n && bus_pins.rw_n && !bus_pins.sel_a && !bus_pins.sel_b)
        else $error("port latch data not driven");

    c_grant: cover property (@(posedge clock) disable iff (!rst_n) $rose(bus_hold_grant));
    c_write: cover property (@(posedge clock) disable iff (!rst_n) $fell(bus_pins.rw_n));
    c_timer_hit: cover property (@(posedge clock) disable iff (!rst_n) tmr_hit);
    c_port: cover property (@(posedge clock) disable iff (!rst_n) $rose(port_latch_clk));

endmodule : cpsys_top

`default_nettype wire

// ---- tb/cpsys_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpsys_mem_model (
    // Clock
    input wire logic clock,
    // Device bus
    input wire cpsys_pkg::cpsys_bus_t bus_pins,
    input wire logic ctl_oe_n,
    input wire logic data_oe_n,
    // Read data
    output logic [7:0] data_in
);
    import cpsys_pkg::*;
    logic [7:0] last_ff = 8'h00;
    wire logic rd_sel;
    wire logic [7:0] rd_val;
    // Answers only a selected read, never while the device drives
    assign rd_sel = !ctl_oe_n && data_oe_n && bus_pins.rw_n
        && (bus_pins.sel_a || bus_pins.sel_b);
    assign rd_val = bus_pins.addr[7:0] ^ (bus_pins.sel_b ? 8'hC3 : 8'h3C);
    // Released bus shows a changing pattern
    assign data_in = rd_sel ? rd_val : ~last_ff;
    always @(posedge clock) begin
        last_ff <= data_in;
    end
endmodule : cpsys_mem_model
`default_nettype wire

// ---- tb/cpu_system_pins_and_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_system_pins_and_timer_tb;
    import cpsys_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic w;
        logic [31:0] d;
        logic [31:0] x;
        logic err;
    } cpsys_row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic wait_in = 1'b0, bus_hold_request = 1'b0, cpu_reset_in = 1'b0;
    logic nonmask_irq_in = 1'b0, maskable_irq_in = 1'b0;
    logic backplate_counter_clk = 1'b0, backup_set_in = 1'b0;
    logic [7:0] parallel_input_lines = 8'hA5;
    logic [31:0] prdata;
    logic pready, pslverr, addr_oe_n, ctl_oe_n, data_oe_n, opcode_fetch_strobe;
    logic port_latch_clk, clock_out_pin, bus_hold_grant, user_flag_a, user_flag_b;
    logic lcd_on_ctl, lcd_divider_tap, backup_state_n;
    logic [7:0] data_in, backplate_lines;
    cpsys_bus_t bus_pins;
    logic [4:0] seen = 5'h00;
    logic [25:0] cap = 26'h000_0000;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    cpsys_row_t rows [8] = '{
        '{OFS_TIMER, 1'b1, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{OFS_TIMER, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{OFS_INP, 1'b0, 32'h0000_0000, 32'h0000_00A5, 1'b0},
        '{OFS_INP, 1'b1, 32'h0000_0001, 32'h0000_0000, 1'b1},
        '{OFS_VEC, 1'b1, 32'h0000_0001, 32'h0000_0000, 1'b1},
        '{8'h1C, 1'b0, 32'h0000_0000, 32'h0000_0000, 1'b1},
        '{OFS_CTRL, 1'b1, 32'h0000_0007, 32'h0000_0000, 1'b0},
        '{OFS_CTRL, 1'b0, 32'h0000_0000, 32'h0000_0007, 1'b0}
    };

    ////////////////////////////////////////////////////////////////////
    cpsys_top #(.TICK_DIV(4)) uut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus_pins(bus_pins),
        .addr_oe_n(addr_oe_n), .ctl_oe_n(ctl_oe_n), .data_oe_n(data_oe_n),
        .data_in(data_in), .opcode_fetch_strobe(opcode_fetch_strobe),
        .port_latch_clk(port_latch_clk), .clock_out_pin(clock_out_pin),
        .wait_in(wait_in), .bus_hold_request(bus_hold_request),
        .bus_hold_grant(bus_hold_grant), .cpu_reset_in(cpu_reset_in),
        .nonmask_irq_in(nonmask_irq_in), .maskable_irq_in(maskable_irq_in),
        .parallel_input_lines(parallel_input_lines), .user_flag_a(user_flag_a),
        .user_flag_b(user_flag_b), .lcd_on_ctl(lcd_on_ctl),
        .lcd_divider_tap(lcd_divider_tap),
        .backplate_counter_clk(backplate_counter_clk),
        .backplate_lines(backplate_lines), .backup_set_in(backup_set_in),
        .backup_state_n(backup_state_n)
    );
    cpsys_mem_model mem (
        .clock(clock), .bus_pins(bus_pins), .ctl_oe_n(ctl_oe_n),
        .data_oe_n(data_oe_n), .data_in(data_in)
    );

    ////////////////////////////////////////////////////////////////////
    initial begin
        forever #2 clock = ~clock;
    end
    always begin
        repeat (5) @(posedge clock);
        backplate_counter_clk <= ~backplate_counter_clk;
    end
    // Bus activity seen per command, plus driven data
    always @(posedge clock) begin
        cyc <= cyc + 1;
        seen <= seen | {bus_pins.sel_a, bus_pins.sel_b, opcode_fetch_strobe,
            port_latch_clk, !bus_pins.rw_n};
        if (bus_pins.rw_n === 1'b0 || port_latch_clk === 1'b1) begin
            cap <= {bus_pins.addr, bus_pins.data, bus_pins.drive_inhibit, data_oe_n};
        end
        if (cyc == 4000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0000_0000, r, e);
        chk(r, x);
    endtask : rdchk

    task automatic run_cmd(input logic [28:0] c, input logic [4:0] xs,
        output logic [31:0] r);
        logic e;
        int n = 0;
        #1 seen = 5'h00;
        apb(OFS_BCMD, 1'b1, {3'b000, c}, r, e);
        do begin
            apb(OFS_BDATA, 1'b0, 32'h0000_0000, r, e);
            n++;
        end while (r[BDATA_BUSY] !== 1'b0 && n < 20);
        chk(seen, xs);
    endtask : run_cmd

    task wrap_up;
        $display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r, p;
        logic e, c;
        int n, adv;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk({addr_oe_n, ctl_oe_n, data_oe_n, bus_hold_grant, backup_state_n}, 5'h1D);
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d, r, e);
            chk(e, rows[i].err);
            if (!rows[i].w && !rows[i].err) begin
                chk(r, rows[i].x);
            end
        end
        chk({lcd_on_ctl, user_flag_b, user_flag_a}, 3'h7);
        p[7:0] = backplate_lines;
        c = lcd_divider_tap;
        repeat (4) @(posedge clock);
        chk(lcd_divider_tap, !c);
        repeat (6) @(posedge clock);
        chk(backplate_lines, {p[6:0], p[7]});
        chk($countones(p[7:0]), 1);
        run_cmd(29'h035A_1234, 5'h09, r);
        chk(cap, {16'h1234, 8'h5A, 2'b10});
        run_cmd(29'h0E00_2345, 5'h14, r);
        chk(r[7:0], 8'h45 ^ 8'h3C);
        run_cmd(29'h0600_0077, 5'h08, r);
        chk(r[7:0], 8'h77 ^ 8'hC3);
        run_cmd(29'h10C6_0000, 5'h02, r);
        chk({cap[9:2], cap[0]}, {8'hC6, 1'b0});
        bus_hold_request <= 1'b1;
        n = 0;
        while (bus_hold_grant !== 1'b1 && n < 10) begin
            @(posedge clock);
            n++;
        end
        chk({addr_oe_n, ctl_oe_n, data_oe_n, bus_hold_grant}, 4'hF);
        bus_hold_request <= 1'b0;
        wait_in <= 1'b1;
        repeat (4) @(posedge clock);
        c = clock_out_pin;
        repeat (8) begin
            @(posedge clock);
            chk(clock_out_pin, c);
        end
        wait_in <= 1'b0;
        repeat (4) @(posedge clock);
        c = clock_out_pin;
        @(posedge clock);
        chk(clock_out_pin, !c);
        apb(OFS_TIMER, 1'b1, 32'h0000_0123, r, e);
        apb(OFS_TIMER, 1'b0, 32'h0000_0000, p, e);
        adv = 0;
        repeat (12) begin
            apb(OFS_TIMER, 1'b0, 32'h0000_0000, r, e);
            chk(r[8:0] == p[8:0] || r[8:0] == {p[0] ^ p[4], p[8:1]}, 1'b1);
            adv += int'(r != p);
            p = r;
        end
        chk(adv > 0, 1'b1);
        backup_set_in <= 1'b1;
        repeat (4) @(posedge clock);
        chk(backup_state_n, 1'b0);
        apb(OFS_CTRL, 1'b1, 32'h0000_0010, r, e);
        repeat (2) @(posedge clock);
        chk(backup_state_n, 1'b1);
        chk(backplate_lines, 8'h00);
        apb(OFS_CTRL, 1'b1, 32'h0000_0008, r, e);
        apb(OFS_TIMER, 1'b1, 32'h0000_01FE, r, e);
        n = 0;
        do begin
            apb(OFS_STAT, 1'b0, 32'h0000_0000, r, e);
            n++;
        end while (r[ST_TMR_PEND] !== 1'b1 && n < 6);
        chk(r[ST_TMR_PEND], 1'b1);
        rdchk(OFS_VEC, {VEC_TMR_LO, VEC_TMR_HI});
        apb(OFS_STAT, 1'b1, 32'h0000_0007, r, e);
        apb(OFS_TIMER, 1'b1, 32'h0000_0000, r, e);
        maskable_irq_in <= 1'b1;
        repeat (8) @(posedge clock);
        rdchk(OFS_VEC, {VEC_MI_LO, VEC_MI_HI});
        apb(OFS_CTRL, 1'b1, 32'h0000_0000, r, e);
        rdchk(OFS_VEC, 32'h0000_0000);
        nonmask_irq_in <= 1'b1;
        repeat (8) @(posedge clock);
        rdchk(OFS_VEC, {VEC_NMI_LO, VEC_NMI_HI});
        cpu_reset_in <= 1'b1;
        repeat (4) @(posedge clock);
        rdchk(OFS_VEC, {VEC_RESET_LO, VEC_RESET_HI});
        wrap_up();
    end
endmodule : cpu_system_pins_and_timer_tb
`default_nettype wire
